// [include/ars_link_if.sv]
// Link between the audio source / host end and the supervised device end.
// The crystal time base is driven by the surroundings, not by either end.
`timescale 1ns/100ps
`default_nettype none
interface ars_link_if;
	logic reset_n;
	logic power_down_request_n;
	logic src_mclk;
	logic bclk;
	logic fclk;
	logic sdata;
	logic crystal_time_base_in;
	logic vol_req;
	logic [ars_pkg::VOL_W-1:0] vol_level;
	modport dev (
		input reset_n,
		input power_down_request_n,
		input src_mclk,
		input bclk,
		input fclk,
		input sdata,
		input crystal_time_base_in,
		input vol_req,
		input vol_level
	);
	modport host (
		output reset_n,
		output power_down_request_n,
		output src_mclk,
		output bclk,
		output fclk,
		output sdata,
		output vol_req,
		output vol_level
	);
endinterface
`default_nettype wire

// [include/ars_pkg.sv]
// Shared constants for the audio reset and clock supervisor pair.
// Assumes a 100 MHz system clock on both ends.
package ars_pkg;
	localparam int CLK_NS = 10;
	// Reset pulse that the controlling end must hold
	localparam int T_RESET_MIN_NS = 400;
	localparam int RESET_MIN_CYC = (T_RESET_MIN_NS + CLK_NS - 1) / CLK_NS;
	// Longest delay from reset to output-state indicator low
	localparam int T_MSTATE_NS = 370;
	localparam int MSTATE_CYC = T_MSTATE_NS / CLK_NS;
	// Control interface stays closed this long after reset release
	localparam int T_CTRL_READY_US = 3000;
	localparam int CTRL_READY_CYC = T_CTRL_READY_US * 1000 / CLK_NS;
	// Master clock cycles needed before power-down release
	localparam int PDN_MCLK_MIN = 5;
	localparam int BCLK_PER_FRAME = 64;
	localparam int DRIFT_MAX = 10;
	localparam int TOL_PCT = 4;
	localparam int XTAL_HZ = 13500000;
	// Supported input rates, oversampling and output rate
	localparam int N_RATES = 7;
	localparam int RATE_HZ [N_RATES] = '{32000, 44100, 48000, 88200, 96000, 176400, 192000};
	localparam int OS_FACTOR [N_RATES] = '{12, 8, 8, 4, 4, 2, 2};
	localparam int PWM_HZ [N_RATES] = '{384000, 352800, 384000, 352800, 384000, 352800, 384000};
	// Host divider taps: master clock /4, bit clock /16, frame /1024
	localparam int HOST_MCLK_BIT = 1;
	localparam int HOST_BCLK_BIT = 3;
	localparam int HOST_DIV_W = HOST_BCLK_BIT + 7;
	localparam int VOL_HOLD_CYC = 8;
	localparam int VOL_W = 8;
	localparam int WORD_W = 64;
	// Reset values
	localparam logic [VOL_W-1:0] VOL_RESET = 8'h00;
	typedef enum logic [1:0] {ARS_OFF, ARS_DETECT, ARS_WAIT_VOL, ARS_RUN} ars_state_t;
	typedef enum logic [2:0] {ARSH_RESET, ARSH_PDN, ARSH_WAIT, ARSH_READY, ARSH_VOL} ars_hstate_t;
endpackage

// [rtl/ars_dev.sv]
// Device end: reset, power-down and clock-rate supervisor of the PWM processor.
// Assumes every link pin is asynchronous to mclk and is sampled at 100 MHz.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - 32 kHz family: twelve times, 384 kHz out
// - 44.1/88.2/176.4 kHz: 8/4/2 times, 352.8 kHz
// - 48/96/192 kHz: 8/4/2 times, 384 kHz
// - frame drift over 10 master clocks resyncs
// - source gives 64 bit clocks per frame
// - host holds reset low 400 ns minimum
// - five master clocks before power-down release
// - rates measured against crystal time base
// - audio only after master volume write
module ars_dev #(
	parameter int CTRL_READY_CYC = ars_pkg::CTRL_READY_CYC,
	parameter int XTAL_HZ = ars_pkg::XTAL_HZ
) (
	input wire logic mclk,
	input wire logic resetn,
	ars_link_if.dev link,
	output logic out_state,
	output logic ctrl_ready,
	output logic rate_locked,
	output logic [3:0] os_factor,
	output logic [18:0] pwm_rate_hz,
	output logic [ars_pkg::VOL_W-1:0] master_volume,
	output logic resync,
	output logic sample_valid,
	output logic [ars_pkg::WORD_W-1:0] sample_data
);
	localparam int NS = 8 + ars_pkg::VOL_W;
	localparam int N = ars_pkg::N_RATES;

	logic [NS-1:0] pin_raw;
	logic [NS-1:0] sync1;
	logic [NS-1:0] sync2;
	logic [4:0] last;
	ars_pkg::ars_state_t state;
	ars_pkg::ars_state_t next_state;
	logic [31:0] ready_cnt;
	logic [7:0] bclk_cnt;
	logic [11:0] xtal_cnt;
	logic [15:0] mck_cnt;
	logic [15:0] prev_mck;
	logic have_prev;
	logic framing_good;
	logic vol_written;
	logic [ars_pkg::WORD_W-1:0] shift;

	assign pin_raw = {link.vol_level, link.vol_req, link.crystal_time_base_in, link.sdata,
		link.fclk, link.bclk, link.src_mclk, link.power_down_request_n, link.reset_n};

	// Two flip-flops per pin; the first stage feeds only the second
	genvar gi;
	generate
		for (gi = 0; gi < NS; gi++) begin : g_sync
			always_ff @(posedge mclk or negedge resetn) begin
				if (!resetn) begin
					sync1[gi] <= 1'b0;
					sync2[gi] <= 1'b0;
				end else begin
					sync1[gi] <= pin_raw[gi];
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	// Synchronised levels and edges
	wire rst_pin_n = sync2[0];
	wire pdn_n = sync2[1];
	wire mck_rise = sync2[2] & ~last[0];
	wire bclk_rise = sync2[3] & ~last[1];
	wire fclk_rise = sync2[4] & ~last[2];
	wire sdata_s = sync2[5];
	wire xtal_rise = sync2[6] & ~last[3];
	wire vol_rise = sync2[7] & ~last[4];
	wire [ars_pkg::VOL_W-1:0] vol_s = sync2[NS-1:8];
	wire active = rst_pin_n & pdn_n;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			last <= 5'h00;
		end else begin
			last <= {sync2[7:6], sync2[4:2]};
		end
	end

	// Rate classification against crystal-derived period windows
	logic [N-1:0] hit;
	generate
		for (gi = 0; gi < N; gi++) begin : g_rate
			localparam int NOM = XTAL_HZ / ars_pkg::RATE_HZ[gi];
			localparam int LO = NOM * (100 - ars_pkg::TOL_PCT) / 100;
			localparam int HI = NOM * (100 + ars_pkg::TOL_PCT) / 100;
			assign hit[gi] = (xtal_cnt >= 12'(LO)) && (xtal_cnt <= 12'(HI));
		end
	endgenerate

	// First matching entry sets oversampling and output rate
	logic [3:0] sel_os;
	logic [18:0] sel_pwm;
	always_comb begin
		sel_os = 4'h0;
		sel_pwm = 19'h00000;
		for (int i = N - 1; i >= 0; i--) begin
			if (hit[i]) begin
				sel_os = 4'(ars_pkg::OS_FACTOR[i]);
				sel_pwm = 19'(ars_pkg::PWM_HZ[i]);
			end
		end
	end

	// Frame checks made at each frame clock rising edge
	wire frame_ok = (bclk_cnt == 8'(ars_pkg::BCLK_PER_FRAME));
	wire [15:0] drift = (mck_cnt > prev_mck) ? mck_cnt - prev_mck : prev_mck - mck_cnt;
	wire drift_bad = have_prev && (drift > 16'(ars_pkg::DRIFT_MAX));
	wire frame_end = fclk_rise && active;
	wire rate_hit = |hit;
	wire lock_ok = have_prev && frame_ok && rate_hit && !drift_bad;

	// Per-frame edge counters, restarted at each frame edge
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bclk_cnt <= 8'h00;
			xtal_cnt <= 12'h000;
			mck_cnt <= 16'h0000;
		end else if (fclk_rise || !active) begin
			bclk_cnt <= {7'h00, bclk_rise};
			xtal_cnt <= {11'h000, xtal_rise};
			mck_cnt <= {15'h0000, mck_rise};
		end else begin
			if (bclk_rise && bclk_cnt != 8'hff)
				bclk_cnt <= bclk_cnt + 8'h01;
			if (xtal_rise && xtal_cnt != 12'hfff)
				xtal_cnt <= xtal_cnt + 12'h001;
			if (mck_rise && mck_cnt != 16'hffff)
				mck_cnt <= mck_cnt + 16'h0001;
		end
	end

	// Previous frame length in master clocks; a resync forgets it
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			prev_mck <= 16'h0000;
			have_prev <= 1'b0;
		end else if (!active) begin
			have_prev <= 1'b0;
		end else if (frame_end) begin
			prev_mck <= mck_cnt;
			have_prev <= !drift_bad;
		end
	end

	// Framing is good only after a full 64-edge frame
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			framing_good <= 1'b0;
		else if (!active)
			framing_good <= 1'b0;
		else if (frame_end)
			framing_good <= frame_ok;
	end

	// Supervisor sequence
	always_comb begin
		next_state = state;
		case (state)
			ars_pkg::ARS_OFF: begin
				if (active)
					next_state = ars_pkg::ARS_DETECT;
			end
			ars_pkg::ARS_DETECT: begin
				if (frame_end && lock_ok)
					next_state = ars_pkg::ARS_WAIT_VOL;
			end
			ars_pkg::ARS_WAIT_VOL: begin
				if (vol_written)
					next_state = ars_pkg::ARS_RUN;
			end
			ars_pkg::ARS_RUN: begin
				next_state = ars_pkg::ARS_RUN;
			end
			default: begin
				next_state = ars_pkg::ARS_OFF;
			end
		endcase
		// Lost lock or drift sends detection round again
		if (state != ars_pkg::ARS_OFF && state != ars_pkg::ARS_DETECT && frame_end)
			if (drift_bad || !rate_hit)
				next_state = ars_pkg::ARS_DETECT;
		if (!active)
			next_state = ars_pkg::ARS_OFF;
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			state <= ars_pkg::ARS_OFF;
		else
			state <= next_state;
	end

	// Latch rate selection at lock; cleared while off
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			os_factor <= 4'h0;
			pwm_rate_hz <= 19'h00000;
		end else if (state == ars_pkg::ARS_DETECT && frame_end && lock_ok) begin
			os_factor <= sel_os;
			pwm_rate_hz <= sel_pwm;
		end else if (state == ars_pkg::ARS_OFF) begin
			os_factor <= 4'h0;
			pwm_rate_hz <= 19'h00000;
		end
	end

	// Control port window: 3 ms counted after the two sync stages, so their latency adds to it
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ready_cnt <= 32'h00000000;
			ctrl_ready <= 1'b0;
		end else if (!rst_pin_n) begin
			ready_cnt <= 32'h00000000;
			ctrl_ready <= 1'b0;
		end else if (ready_cnt >= 32'(CTRL_READY_CYC - 1)) begin
			ctrl_ready <= 1'b1;
		end else begin
			ready_cnt <= ready_cnt + 32'h00000001;
		end
	end

	// Volume command accepted only while the control port is open
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			vol_written <= 1'b0;
			master_volume <= ars_pkg::VOL_RESET;
		end else if (!rst_pin_n) begin
			vol_written <= 1'b0;
			master_volume <= ars_pkg::VOL_RESET;
		end else if (vol_rise && ctrl_ready) begin
			vol_written <= 1'b1;
			master_volume <= vol_s;
		end
	end

	// Bit capture, MSB first, on bit clock rising edges
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			shift <= 64'h0;
		else if (bclk_rise)
			shift <= {shift[ars_pkg::WORD_W-2:0], sdata_s};
	end

	// Leaving run on this frame edge drops the sample, so the indicator covers every one
	wire run_stays = (state == ars_pkg::ARS_RUN) && (next_state == ars_pkg::ARS_RUN);

	// Frame hand-off; bad frames and frames after bad ones are dropped
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			sample_valid <= 1'b0;
			sample_data <= 64'h0;
		end else begin
			sample_valid <= 1'b0;
			if (frame_end && frame_ok && framing_good && run_stays) begin
				sample_valid <= 1'b1;
				sample_data <= shift;
			end
		end
	end

	// Indicator drops three cycles after the pin, well inside the limit
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			out_state <= 1'b0;
			rate_locked <= 1'b0;
			resync <= 1'b0;
		end else begin
			out_state <= (next_state == ars_pkg::ARS_RUN);
			rate_locked <= (next_state == ars_pkg::ARS_WAIT_VOL)
				|| (next_state == ars_pkg::ARS_RUN);
			resync <= frame_end && drift_bad;
		end
	end
endmodule
`default_nettype wire

// [rtl/ars_host.sv]
// Host end: drives reset, power-down, the serial audio clocks and volume.
// Assumes the device samples these pins on its own 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module ars_host #(
	parameter int CTRL_READY_CYC = ars_pkg::CTRL_READY_CYC
) (
	input wire logic mclk,
	input wire logic resetn,
	ars_link_if.host link,
	input wire logic sleep,
	input wire logic vol_cmd_valid,
	input wire logic [ars_pkg::VOL_W-1:0] vol_cmd_level,
	output logic vol_cmd_ready,
	input wire logic [ars_pkg::WORD_W-1:0] frame_word,
	output logic frame_taken
);
	localparam int DW = ars_pkg::HOST_DIV_W;
	ars_pkg::ars_hstate_t state;
	logic [DW-1:0] div;
	logic [31:0] cnt;
	logic [ars_pkg::WORD_W-1:0] word;
	logic mck_q;

	// Free-running divider: frame edges fall on bit clock falling edges
	wire frame_start = (div == '0);
	wire mck_rise = div[ars_pkg::HOST_MCLK_BIT] & ~mck_q;
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			div <= '0;
			mck_q <= 1'b0;
		end else begin
			div <= div + 1'b1;
			mck_q <= div[ars_pkg::HOST_MCLK_BIT];
		end
	end

	// Word loaded at frame start, shifted out MSB first
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			word <= 64'h0;
			frame_taken <= 1'b0;
		end else begin
			frame_taken <= frame_start;
			if (frame_start)
				word <= frame_word;
		end
	end

	// Sixty-four bit clocks per frame clock period
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			link.src_mclk <= 1'b0;
			link.bclk <= 1'b0;
			link.fclk <= 1'b0;
			link.sdata <= 1'b0;
		end else begin
			link.src_mclk <= div[ars_pkg::HOST_MCLK_BIT];
			link.bclk <= div[ars_pkg::HOST_BCLK_BIT];
			// Frame edge at divider wrap, so the word's top bit leads each frame
			link.fclk <= ~div[DW-1];
			link.sdata <= word[~div[DW-1:ars_pkg::HOST_BCLK_BIT+1]];
		end
	end

	// Sequence: reset pulse, clocked power-down release, 3 ms wait
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state <= ars_pkg::ARSH_RESET;
			cnt <= 32'h00000000;
			link.reset_n <= 1'b0;
			link.power_down_request_n <= 1'b0;
			link.vol_req <= 1'b0;
			link.vol_level <= ars_pkg::VOL_RESET;
		end else begin
			case (state)
				ars_pkg::ARSH_RESET: begin
					cnt <= cnt + 32'h00000001;
					if (cnt >= 32'(ars_pkg::RESET_MIN_CYC)) begin
						link.reset_n <= 1'b1;
						cnt <= 32'h00000000;
						state <= ars_pkg::ARSH_PDN;
					end
				end
				ars_pkg::ARSH_PDN: begin
					if (mck_rise && !sleep)
						cnt <= cnt + 32'h00000001;
					if (cnt >= 32'(ars_pkg::PDN_MCLK_MIN)) begin
						link.power_down_request_n <= 1'b1;
						cnt <= 32'h00000000;
						state <= ars_pkg::ARSH_WAIT;
					end
				end
				ars_pkg::ARSH_WAIT: begin
					cnt <= cnt + 32'h00000001;
					if (cnt >= 32'(CTRL_READY_CYC))
						state <= ars_pkg::ARSH_READY;
				end
				ars_pkg::ARSH_READY: begin
					cnt <= 32'h00000000;
					if (vol_cmd_valid) begin
						link.vol_level <= vol_cmd_level;
						link.vol_req <= 1'b1;
						state <= ars_pkg::ARSH_VOL;
					end
				end
				ars_pkg::ARSH_VOL: begin
					cnt <= cnt + 32'h00000001;
					if (cnt >= 32'(ars_pkg::VOL_HOLD_CYC)) begin
						link.vol_req <= 1'b0;
						cnt <= 32'h00000000;
						state <= ars_pkg::ARSH_READY;
					end
				end
				default: begin
					state <= ars_pkg::ARSH_RESET;
				end
			endcase
			// Sleep forces power-down; release again needs fresh clocks
			if (sleep && state != ars_pkg::ARSH_RESET) begin
				link.power_down_request_n <= 1'b0;
				link.vol_req <= 1'b0;
				cnt <= 32'h00000000;
				state <= ars_pkg::ARSH_PDN;
			end
		end
	end

	// Command port open only in the ready state
	assign vol_cmd_ready = (state == ars_pkg::ARSH_READY) && !sleep;
endmodule
`default_nettype wire

// [verif/ars_link_props.sv]
// Checker for the supervisor link pins and the device's status outputs.
// Instantiated by the bench beside the link; sees plain signals only.
`timescale 1ns/100ps
`default_nettype none
module ars_link_props #(
	parameter int CTRL_READY_CYC = ars_pkg::CTRL_READY_CYC
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic reset_n,
	input wire logic power_down_request_n,
	input wire logic src_mclk,
	input wire logic bclk,
	input wire logic fclk,
	input wire logic out_state,
	input wire logic ctrl_ready,
	input wire logic rate_locked,
	input wire logic [3:0] os_factor,
	input wire logic [18:0] pwm_rate_hz,
	input wire logic sample_valid
);
	logic pb, pf, pm, seen;
	logic [7:0] bcnt, last_cnt, mcnt;
	int lo_cnt, hi_cnt;
	wire b_rise = bclk & ~pb;
	wire f_rise = fclk & ~pf;
	wire m_rise = src_mclk & ~pm;
	wire link_up = reset_n & power_down_request_n;
	// Edge history of the link clocks
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pb <= 1'b0;
			pf <= 1'b0;
			pm <= 1'b0;
		end else begin
			pb <= bclk;
			pf <= fclk;
			pm <= src_mclk;
		end
	end
	// Bit clocks per frame; a cut frame during reset or sleep is not judged
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			bcnt <= 8'h00;
			last_cnt <= 8'h00;
			seen <= 1'b0;
		end else if (!link_up) begin
			bcnt <= 8'h00;
			seen <= 1'b0;
		end else if (f_rise) begin
			last_cnt <= bcnt;
			bcnt <= {7'h00, b_rise};
			seen <= 1'b1;
		end else if (bcnt != 8'hff) begin
			bcnt <= bcnt + {7'h00, b_rise};
		end
	end
	// Master clocks seen while power-down held, and reset level durations
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mcnt <= 8'h00;
			lo_cnt <= 0;
			hi_cnt <= 0;
		end else begin
			mcnt <= power_down_request_n ? 8'h00 : mcnt + {7'h00, m_rise && mcnt != 8'hff};
			lo_cnt <= reset_n ? 0 : lo_cnt + 1;
			hi_cnt <= reset_n ? hi_cnt + 1 : 0;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_reset_pulse_len: assert property ($rose(reset_n) |-> lo_cnt >= ars_pkg::RESET_MIN_CYC)
		else $error("reset pulse shorter than minimum");
	a_mclk_before_pdn: assert property ($rose(power_down_request_n) |-> mcnt >= 8'h05)
		else $error("too few master clocks before power-down release");
	a_bclk_per_frame: assert property (f_rise && seen && link_up |-> bcnt == 8'h40)
		else $error("bit clock count per frame wrong");
	a_state_on_reset: assert property ($fell(reset_n) |-> ##[0:37] !out_state)
		else $error("output state not low after reset");
	a_state_on_pdn: assert property ($fell(power_down_request_n) |-> ##[0:37] !out_state)
		else $error("output state not low after power-down");
	a_ctrl_wait_time: assert property ($rose(ctrl_ready) |-> hi_cnt >= CTRL_READY_CYC)
		else $error("control port opened early");
	a_rate_pairing: assert property (rate_locked |-> (os_factor == 4'hc && pwm_rate_hz == 19'h5dc00)
		|| (os_factor inside {4'h8, 4'h4, 4'h2} && pwm_rate_hz inside {19'h5dc00, 19'h56220}))
		else $error("oversampling and output rate mismatch");
	a_audio_needs_state: assert property (sample_valid |-> out_state)
		else $error("audio sample while outputs off");
	a_frame_count_ok: assert property (sample_valid |-> last_cnt == 8'h40)
		else $error("sample from badly framed input");
endmodule
`default_nettype wire

// [verif/tb.sv]
// Bench: host end and device end joined by the link, judged end to end.
// Assumes the crystal input is made here with an 80 ns period.
`timescale 1ns/100ps
`default_nettype none
module tb;
	localparam int CTRL_CYC = 50;
	localparam logic [63:0] WORD = 64'h0123_4567_89ab_cdef;
	logic mclk, dev_resetn, host_resetn, xtal, sleep, vol_cmd_valid, vol_cmd_ready, frame_taken;
	logic out_state, ctrl_ready, rate_locked, resync, sample_valid;
	logic [3:0] os_factor;
	logic [18:0] pwm_rate_hz;
	logic [7:0] vol_cmd_level, master_volume;
	logic [63:0] frame_word, sample_data;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	ars_link_if link();
	assign link.crystal_time_base_in = xtal;
	ars_dev #(.CTRL_READY_CYC(CTRL_CYC), .XTAL_HZ(12500000)) ars_dev_i (.mclk(mclk),
		.resetn(dev_resetn), .link(link), .out_state(out_state), .ctrl_ready(ctrl_ready),
		.rate_locked(rate_locked), .os_factor(os_factor), .pwm_rate_hz(pwm_rate_hz),
		.master_volume(master_volume), .resync(resync), .sample_valid(sample_valid),
		.sample_data(sample_data));
	ars_host #(.CTRL_READY_CYC(CTRL_CYC)) ars_host_i (.mclk(mclk), .resetn(host_resetn),
		.link(link), .sleep(sleep), .vol_cmd_valid(vol_cmd_valid),
		.vol_cmd_level(vol_cmd_level), .vol_cmd_ready(vol_cmd_ready),
		.frame_word(frame_word), .frame_taken(frame_taken));
	ars_link_props #(.CTRL_READY_CYC(CTRL_CYC)) ars_link_props_i (.mclk(mclk),
		.resetn(dev_resetn), .reset_n(link.reset_n),
		.power_down_request_n(link.power_down_request_n), .src_mclk(link.src_mclk),
		.bclk(link.bclk), .fclk(link.fclk), .out_state(out_state), .ctrl_ready(ctrl_ready),
		.rate_locked(rate_locked), .os_factor(os_factor), .pwm_rate_hz(pwm_rate_hz),
		.sample_valid(sample_valid));
	// Clocks: system 100 MHz, crystal free running
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		xtal = 1'b0;
		forever #40 xtal = ~xtal;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Counts audio samples over a span; silence expected
	task automatic quiet_span();
		int n;
		int r;
		int f;
		n = 0;
		r = 0;
		f = 0;
		repeat (2500) begin
			@(negedge mclk);
			if (sample_valid !== 1'b0) n++;
			if (resync !== 1'b0) r++;
			if (frame_taken !== 1'b0) f++;
		end
		chk(n, 0);
		chk(r, 0);
		// Steady framing: two or three frame loads in the span
		chk(f / 2, 1);
	endtask
	task automatic t_startup();
		chk(out_state, 1'b0);
		chk(ctrl_ready, 1'b0);
		for (int i = 0; i < 2000 && vol_cmd_ready !== 1'b1; i++) @(negedge mclk);
		chk(ctrl_ready, 1'b1);
		for (int i = 0; i < 6000 && rate_locked !== 1'b1; i++) @(negedge mclk);
		chk(os_factor, 4'h4);
		chk(pwm_rate_hz, 19'h5dc00);
		chk(out_state, 1'b0);
	endtask
	task automatic t_volume();
		@(posedge mclk);
		vol_cmd_level <= 8'h5a;
		vol_cmd_valid <= 1'b1;
		@(posedge mclk);
		vol_cmd_valid <= 1'b0;
		for (int i = 0; i < 40 && master_volume !== 8'h5a; i++) @(negedge mclk);
		chk(master_volume, 8'h5a);
		for (int i = 0; i < 3000 && sample_valid !== 1'b1; i++) @(negedge mclk);
		chk(out_state, 1'b1);
		chk(sample_data, WORD);
	endtask
	task automatic t_sleep();
		@(posedge mclk);
		sleep <= 1'b1;
		for (int i = 0; i < 40 && out_state !== 1'b0; i++) @(negedge mclk);
		chk(out_state, 1'b0);
		quiet_span();
		chk(rate_locked, 1'b0);
		@(posedge mclk);
		sleep <= 1'b0;
		for (int i = 0; i < 9000 && out_state !== 1'b1; i++) @(negedge mclk);
		chk(out_state, 1'b1);
	endtask
	// Host reset in mid-run clears the volume flag, so audio stays off
	task automatic t_host_reset();
		@(posedge mclk);
		host_resetn <= 1'b0;
		@(posedge mclk);
		host_resetn <= 1'b1;
		for (int i = 0; i < 40 && out_state !== 1'b0; i++) @(negedge mclk);
		chk(out_state, 1'b0);
		for (int i = 0; i < 9000 && rate_locked !== 1'b1; i++) @(negedge mclk);
		chk(rate_locked, 1'b1);
		quiet_span();
		chk(out_state, 1'b0);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Hang guard, well above the expected run length
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		dev_resetn = 1'b0;
		host_resetn = 1'b0;
		sleep = 1'b0;
		vol_cmd_valid = 1'b0;
		vol_cmd_level = 8'h00;
		frame_word = WORD;
		repeat (2) @(posedge mclk);
		dev_resetn <= 1'b1;
		host_resetn <= 1'b1;
		t_startup();
		t_volume();
		t_sleep();
		t_host_reset();
		tally_and_finish();
	end
endmodule
`default_nettype wire
